// ===== rtl/cmw_regs.vh
// Constants for the compare-match waveform output block
`ifndef CMW_REGS_VH
`define CMW_REGS_VH
// Waveform channel modes
`define CMW_WMODE_SINGLE 2'h0
`define CMW_WMODE_PHASE  2'h1
`define CMW_WMODE_SR     2'h2
`define CMW_WMODE_GR     2'h3
// General-register channel actions
`define CMW_GACT_LOW     2'h0
`define CMW_GACT_HIGH    2'h1
`define CMW_GACT_TOGGLE  2'h2
// Divided-clock pin functions
`define CMW_DIV_OFF      3'h0
`define CMW_DIV_2        3'h1
`define CMW_DIV_4        3'h2
`define CMW_DIV_8        3'h3
`define CMW_DIV_CMP      3'h4
// Compare 0/1 actions
`define CMW_CACT_HOLD    2'h0
`define CMW_CACT_INV     2'h1
`define CMW_CACT_LOW     2'h2
`define CMW_CACT_HIGH    2'h3
// Reset values
`define CMW_CNT_RST      16'h0000
`define CMW_DIVCNT_RST   3'h0
`endif

// ===== rtl/cmw_divclk.v
// Divided-clock compare pin driver
`timescale 1ns/100ps
module cmw_divclk
(
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // Control
    input  wire       run,
    input  wire [2:0] func_sel,
    input  wire       init_level,
    input  wire       match8,
    // Pin
    output reg        pin_out
);
`include "cmw_regs.vh"

    reg  [2:0] div_cnt_r;

    // Free prescaler counts only while running
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            div_cnt_r <= `CMW_DIVCNT_RST;
        else if (run)
            div_cnt_r <= div_cnt_r + 3'h1;
    end

    // Pin level per selected function; registered so no glitch reaches the pin
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pin_out <= 1'b0;
        else if (!run)
            pin_out <= init_level;
        else
        begin
            case (func_sel)
                `CMW_DIV_OFF: pin_out <= 1'b0;
                `CMW_DIV_2:   pin_out <= div_cnt_r[0];
                `CMW_DIV_4:   pin_out <= div_cnt_r[1];
                `CMW_DIV_8:   pin_out <= div_cnt_r[2];
                `CMW_DIV_CMP: pin_out <= pin_out ^ match8;
                default:      pin_out <= 1'b0;
            endcase
        end
    end
endmodule

// ===== rtl/cmw_top.v
// Compare-match waveform output stage, top level
`timescale 1ns/100ps
// Functional notes
// - Single mode: high on match, low at zero
// - Phase mode: toggle output on every match
// - SR mode: even sets, next odd clears
// - General channel: low, high or toggle
// - Divided pin: off, div2, div4, div8
// - Divided pin compare mode toggles on match
// - Compare 0/1: hold, invert, low, high
// - Outputs start at configured initial level
// - Compare 0 group inversion of three outputs
// - Compare 1 group inversion of three outputs
// - Immediate reload updates active match now
// - Deferred reload transfers at counter reset
// - Reload off: compare 1 keeps counting
// - Reload on: compare 1 clears counter
// - Overflow interrupt only when enabled
// - Per-channel compare interrupt enables
// - Priority level presented with each request
// - Shared mode: matches use overflow level
module cmw_top
#(
    parameter NCH = 8,
    parameter CW  = 16,
    parameter PW  = 3
)
(
    // Clock and reset
    input  wire              clk_sys,
    input  wire              rst,
    // Base counter control
    input  wire              run,
    input  wire              reload_en,
    input  wire              deferred_reload,
    // Waveform channels
    input  wire [2*NCH-1:0]  wave_mode,
    input  wire [2*NCH-1:0]  gr_action,
    input  wire [NCH-1:0]    init_level,
    input  wire [NCH-1:0]    match_wr,
    input  wire [CW*NCH-1:0] match_wdata,
    // Compare 0/1 group
    input  wire [CW-1:0]     compare0_val,
    input  wire [CW-1:0]     compare1_val,
    input  wire [1:0]        compare0_action,
    input  wire [1:0]        compare1_action,
    input  wire [1:0]        cmp_init_level,
    input  wire              cmp0_invert,
    input  wire              cmp1_invert,
    // Divided-clock pin
    input  wire [2:0]        div_func,
    input  wire [7:0]        div_compare_val,
    input  wire              div_init_level,
    // Interrupts
    input  wire              ovf_irq_en,
    input  wire [NCH+1:0]    cmp_irq_en,
    input  wire [PW-1:0]     ovf_prio,
    input  wire [PW-1:0]     cmp_prio,
    input  wire              share_prio,
    // Outputs
    output reg  [NCH-1:0]    wave_out,
    output wire [2:0]        compare0_group_output,
    output wire [2:0]        compare1_group_output,
    output wire              divided_clock_compare_pin,
    output reg  [CW-1:0]     count_r,
    output reg               ovf_irq,
    output reg  [NCH+1:0]    cmp_irq,
    output reg  [PW-1:0]     ovf_irq_prio,
    output reg  [PW-1:0]     cmp_irq_prio
);
`include "cmw_regs.vh"

    // Two-bit mode or action field selector for channel i
    function [1:0] field2;
        input [2*NCH-1:0] vec;
        input integer     idx;
        begin
            field2 = vec[2*idx +: 2];
        end
    endfunction

    reg  [CW*NCH-1:0] waveform_match_reg;
    reg  [CW*NCH-1:0] pend_r;
    reg  [1:0]        cmp_lvl_r;
    reg  [CW-1:0]     count_nxt;
    wire [NCH-1:0]    ch_match;
    wire              cmp0_hit;
    wire              cmp1_hit;
    wire              at_zero;
    wire              ovf_hit;
    wire              base_reset;

    assign cmp0_hit   = run && (count_r == compare0_val);
    assign cmp1_hit   = run && (count_r == compare1_val);
    assign ovf_hit    = run && (count_r == {CW{1'b1}});
    assign at_zero    = run && (count_r == `CMW_CNT_RST);
    // Counter reset event: wrap or compare-1 clear
    assign base_reset = ovf_hit || (cmp1_hit && reload_en);

    // Next counter value; compare 1 clears only with reload on
    always @*
    begin
        count_nxt = count_r;
        if (run)
        begin
            if (cmp1_hit && reload_en)
                count_nxt = `CMW_CNT_RST;
            else
                count_nxt = count_r + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            count_r <= `CMW_CNT_RST;
        else
            count_r <= count_nxt;
    end

    // Per-channel match registers, outputs and flags
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            assign ch_match[g] = run && (count_r == waveform_match_reg[CW*g +: CW]);

            // Deferred writes wait for a counter reset; avoids mid-period glitches
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    waveform_match_reg[CW*g +: CW] <= {CW{1'b0}};
                    pend_r[CW*g +: CW]             <= {CW{1'b0}};
                end
                else
                begin
                    if (match_wr[g])
                        pend_r[CW*g +: CW] <= match_wdata[CW*g +: CW];
                    if (match_wr[g] && !deferred_reload)
                        waveform_match_reg[CW*g +: CW] <= match_wdata[CW*g +: CW];
                    else if (deferred_reload && base_reset)
                        waveform_match_reg[CW*g +: CW] <= pend_r[CW*g +: CW];
                end
            end

            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    wave_out[g] <= 1'b0;
                else if (!run)
                    wave_out[g] <= init_level[g];
                else
                begin
                    case (field2(wave_mode, g))
                        `CMW_WMODE_SINGLE:
                        begin
                            if (ch_match[g])
                                wave_out[g] <= 1'b1;
                            else if (at_zero)
                                wave_out[g] <= 1'b0;
                        end
                        `CMW_WMODE_PHASE:
                            wave_out[g] <= wave_out[g] ^ ch_match[g];
                        `CMW_WMODE_SR:
                        begin
                            // Only even channels with an odd partner; others hold
                            if ((g % 2 == 0) && (g + 1 < NCH))
                            begin
                                if (ch_match[g])
                                    wave_out[g] <= 1'b1;
                                else if (ch_match[(g + 1) % NCH])
                                    wave_out[g] <= 1'b0;
                            end
                        end
                        default:
                        begin
                            if (ch_match[g])
                            begin
                                case (field2(gr_action, g))
                                    `CMW_GACT_LOW:    wave_out[g] <= 1'b0;
                                    `CMW_GACT_HIGH:   wave_out[g] <= 1'b1;
                                    `CMW_GACT_TOGGLE: wave_out[g] <= ~wave_out[g];
                                    default:          wave_out[g] <= wave_out[g];
                                endcase
                            end
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Compare 0/1 output levels
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_cmp
            wire [1:0] act = (g == 0) ? compare0_action : compare1_action;
            wire       hit = (g == 0) ? cmp0_hit : cmp1_hit;
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    cmp_lvl_r[g] <= 1'b0;
                else if (!run)
                    cmp_lvl_r[g] <= cmp_init_level[g];
                else if (hit)
                begin
                    case (act)
                        `CMW_CACT_HOLD: cmp_lvl_r[g] <= cmp_lvl_r[g];
                        `CMW_CACT_INV:  cmp_lvl_r[g] <= ~cmp_lvl_r[g];
                        `CMW_CACT_LOW:  cmp_lvl_r[g] <= 1'b0;
                        `CMW_CACT_HIGH: cmp_lvl_r[g] <= 1'b1;
                        default:        cmp_lvl_r[g] <= cmp_lvl_r[g];
                    endcase
                end
            end
        end
    endgenerate

    // Group inversion is a plain XOR on registered levels
    assign compare0_group_output = {3{cmp_lvl_r[0] ^ cmp0_invert}};
    assign compare1_group_output = {3{cmp_lvl_r[1] ^ cmp1_invert}};

    cmw_divclk u_div
    (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .run        (run),
        .func_sel   (div_func),
        .init_level (div_init_level),
        .match8     (run && (count_r[7:0] == div_compare_val)),
        .pin_out    (divided_clock_compare_pin)
    );

    // Interrupt requests: one-cycle pulses with their priority
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ovf_irq      <= 1'b0;
            cmp_irq      <= {(NCH+2){1'b0}};
            ovf_irq_prio <= {PW{1'b0}};
            cmp_irq_prio <= {PW{1'b0}};
        end
        else
        begin
            ovf_irq      <= ovf_hit && ovf_irq_en;
            cmp_irq      <= {cmp1_hit, cmp0_hit, ch_match} & cmp_irq_en;
            ovf_irq_prio <= ovf_prio;
            cmp_irq_prio <= share_prio ? ovf_prio : cmp_prio;
        end
    end
endmodule

// ===== tb/cmw_top_sva.sv
// Assertion checker for the compare-match waveform top
`timescale 1ns/100ps
module cmw_top_chk
#(
    parameter NCH = 8,
    parameter CW  = 16,
    parameter PW  = 3
)
(
    // Clock, reset, control
    input wire              clk_sys,
    input wire              rst,
    input wire              run,
    input wire              reload_en,
    input wire [NCH-1:0]    init_level,
    input wire              div_init_level,
    // Compare settings
    input wire [CW-1:0]     compare0_val,
    input wire [CW-1:0]     compare1_val,
    input wire [1:0]        compare0_action,
    input wire              cmp0_invert,
    input wire [2:0]        div_func,
    input wire [7:0]        div_compare_val,
    // Interrupt settings
    input wire              ovf_irq_en,
    input wire [NCH+1:0]    cmp_irq_en,
    input wire [PW-1:0]     ovf_prio,
    input wire              share_prio,
    // Outputs
    input wire [NCH-1:0]    wave_out,
    input wire [2:0]        compare0_group_output,
    input wire              divided_clock_compare_pin,
    input wire [CW-1:0]     count_r,
    input wire              ovf_irq,
    input wire [NCH+1:0]    cmp_irq,
    input wire [PW-1:0]     cmp_irq_prio
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Counter behaviour around the compare 1 value
    AST_RELOAD_CLR: assert property (run && reload_en && count_r == compare1_val |=> count_r == 0)
        else $error("counter not cleared on compare 1");
    AST_NO_RELOAD: assert property (run && !reload_en && count_r == compare1_val && !(&count_r)
        |=> count_r == $past(count_r) + 1'b1)
        else $error("counter stopped on compare 1");
    // Requests and their levels
    AST_OVF: assert property (ovf_irq |-> $past(run && ovf_irq_en && (&count_r)))
        else $error("overflow request without cause");
    AST_CMP0_IRQ: assert property (run && cmp_irq_en[NCH] && count_r == compare0_val |=> cmp_irq[NCH])
        else $error("compare 0 request missing");
    AST_SHARE: assert property (|cmp_irq && $past(share_prio) |-> cmp_irq_prio == $past(ovf_prio))
        else $error("shared level not presented");
    // Output levels
    AST_CMP0_HIGH: assert property (run && compare0_action == 2'h3 && count_r == compare0_val
        |=> compare0_group_output == {3{~cmp0_invert}})
        else $error("compare 0 set high failed");
    // Skip the edges right after reset, where outputs still show reset zeros
    AST_INIT: assert property (!run && !$past(rst) ##1 !run |-> wave_out == $past(init_level)
        && divided_clock_compare_pin == $past(div_init_level))
        else $error("initial levels not held");
    AST_DIV_CMP: assert property (run && div_func == 3'h4 && count_r[7:0] == div_compare_val
        |=> divided_clock_compare_pin != $past(divided_clock_compare_pin))
        else $error("divided pin did not toggle");
    COV_OVF: cover property (ovf_irq);
    COV_CLR: cover property (run && reload_en && count_r == compare1_val);
    COV_CH0: cover property (cmp_irq[0]);
endmodule

bind cmw_top cmw_top_chk #(.NCH(NCH), .CW(CW), .PW(PW)) i_chk (.clk_sys, .rst, .run, .reload_en, .init_level,
    .div_init_level, .compare0_val, .compare1_val, .compare0_action, .cmp0_invert, .div_func, .div_compare_val,
    .ovf_irq_en, .cmp_irq_en, .ovf_prio, .share_prio, .wave_out, .compare0_group_output,
    .divided_clock_compare_pin, .count_r, .ovf_irq, .cmp_irq, .cmp_irq_prio);

// ===== tb/cmw_pin_mon.sv
// Load on the divided-clock pin that counts its level changes
`timescale 1ns/100ps
module cmw_pin_mon
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Watched pin and count clear
    input  wire        pin,
    input  wire        clr,
    // Changes since clear
    output reg  [15:0] edges_r
);
    reg last_r;
    // A load sees only edges, so count changes between samples
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            last_r  <= 1'b0;
            edges_r <= 16'h0000;
        end
        else
        begin
            last_r  <= pin;
            edges_r <= clr ? 16'h0000 : edges_r + {15'h0000, pin ^ last_r};
        end
    end
endmodule

// ===== tb/cmw_top_tb.sv
// Self-checking bench for the compare-match waveform top
`timescale 1ns/100ps
module cmw_top_tb;
    logic         clk_sys, rst, run, reload_en, deferred_reload, cmp0_invert, cmp1_invert;
    logic         div_init_level, ovf_irq_en, share_prio, mon_clr, divided_clock_compare_pin, ovf_irq;
    logic [15:0]  wave_mode, gr_action, compare0_val, compare1_val, count_r, edges;
    logic [7:0]   init_level, match_wr, div_compare_val, wave_out;
    logic [127:0] match_wdata;
    logic [1:0]   compare0_action, compare1_action, cmp_init_level;
    logic [2:0]   div_func, ovf_prio, cmp_prio, ovf_irq_prio, cmp_irq_prio;
    logic [2:0]   compare0_group_output, compare1_group_output;
    logic [9:0]   cmp_irq_en, cmp_irq;
    int           err_total, num_checks, cyc;

    cmw_top i_dut (.clk_sys, .rst, .run, .reload_en, .deferred_reload, .wave_mode, .gr_action, .init_level,
        .match_wr, .match_wdata, .compare0_val, .compare1_val, .compare0_action, .compare1_action,
        .cmp_init_level, .cmp0_invert, .cmp1_invert, .div_func, .div_compare_val, .div_init_level,
        .ovf_irq_en, .cmp_irq_en, .ovf_prio, .cmp_prio, .share_prio, .wave_out, .compare0_group_output,
        .compare1_group_output, .divided_clock_compare_pin, .count_r, .ovf_irq, .cmp_irq, .ovf_irq_prio,
        .cmp_irq_prio);
    cmw_pin_mon i_mon (.clk_sys, .rst, .pin(divided_clock_compare_pin), .clr(mon_clr), .edges_r(edges));

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Settle at the falling edge until the counter shows v
    task automatic upto(logic [15:0] v);
        int n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end while (count_r !== v && n < 70000);
        if (n == 70000) chk("wait", 1, 0);
    endtask
    task automatic wr(int ch, logic [15:0] v);
        @(posedge clk_sys);
        match_wdata[ch*16 +: 16] <= v;
        match_wr <= 8'h01 << ch;
        @(posedge clk_sys);
        match_wr <= 8'h00;
    endtask
    task automatic t_reset();
        repeat (2) @(negedge clk_sys);
        chk("init", {wave_out, compare0_group_output, compare1_group_output}, 14'h16b8);
        chk("init div", divided_clock_compare_pin, 1'b1);
        chk("idle", {count_r, ovf_irq, cmp_irq}, 0);
    endtask
    task automatic t_wave();
        logic [15:0] at [7] = '{16'h5, 16'h9, 16'h11, 16'h19, 16'h21, 16'h1, 16'h9};
        logic [4:0] ex [7] = '{5'h04, 5'h06, 5'h07, 5'h17, 5'h13, 5'h12, 5'h14};
        for (int i = 0; i < 7; i++)
        begin
            upto(at[i]);
            chk("wave", wave_out[4:0], ex[i]);
            if (i == 2) chk("irq", {cmp_irq, cmp_irq_prio}, {10'h001, 3'h5});
        end
    endtask
    task automatic t_reload();
        upto(16'h0002);
        @(posedge clk_sys);
        deferred_reload <= 1'b1;
        wr(0, 16'h000c);
        upto(16'h000d);
        chk("deferred hold", wave_out[0], 1'b0);
        upto(16'h000d);
        chk("deferred take", wave_out[0], 1'b1);
        upto(16'h0002);
        @(posedge clk_sys);
        deferred_reload <= 1'b0;
        wr(0, 16'h0006);
        upto(16'h0007);
        chk("immediate", wave_out[0], 1'b1);
    endtask
    task automatic t_group();
        logic p0, p1, e0, e1;
        for (int a = 0; a < 4; a++)
        begin
            @(posedge clk_sys);
            {compare0_action, compare1_action} <= {a[1:0], a[1:0]};
            upto(16'h0028);
            p0 = compare0_group_output[0];
            p1 = compare1_group_output[0];
            e0 = (a == 0) ? p0 : (a == 1) ? !p0 : (a == 3);
            e1 = (a == 0) ? p1 : (a == 1) ? !p1 : (a == 3);
            upto(16'h0029);
            chk("grp0", compare0_group_output, {3{e0}});
            upto(16'h0000);
            chk("grp1", compare1_group_output, {3{e1}});
        end
        @(posedge clk_sys);
        {cmp0_invert, cmp1_invert} <= 2'b11;
        @(negedge clk_sys);
        chk("inverted", {compare0_group_output, compare1_group_output}, 6'h00);
        @(posedge clk_sys);
        {cmp0_invert, cmp1_invert} <= 2'b00;
        @(negedge clk_sys);
        chk("plain", {compare0_group_output, compare1_group_output}, 6'h3f);
    endtask
    task automatic t_ovf();
        @(posedge clk_sys);
        {reload_en, share_prio} <= 2'b01;
        upto(16'h002f);
        repeat (3) @(negedge clk_sys);
        chk("no clear", count_r, 16'h0032);
        upto(16'hffff);
        @(negedge clk_sys);
        chk("wrap", {count_r, ovf_irq, ovf_irq_prio}, {16'h0000, 1'b1, 3'h2});
        upto(16'h0009);
        chk("shared", {cmp_irq[1], cmp_irq_prio}, {1'b1, 3'h2});
    endtask
    task automatic t_div();
        logic [15:0] ex [4] = '{16'd16, 16'd8, 16'd4, 16'd1};
        for (int f = 1; f < 5; f++)
        begin
            @(posedge clk_sys);
            div_func <= f[2:0];
            repeat (8) @(posedge clk_sys);
            mon_clr <= 1'b1;
            @(posedge clk_sys);
            mon_clr <= 1'b0;
            repeat ((f == 4) ? 256 : 16) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("div edges", edges, ex[f-1]);
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Hang guard well above the one full counter wrap
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        {rst, run, reload_en, deferred_reload, ovf_irq_en, share_prio, mon_clr} = 7'h54;
        {cmp0_invert, cmp1_invert, div_init_level, cmp_init_level, div_func} = 8'h28;
        {wave_mode, gr_action, compare0_val, compare1_val} = {16'h03a4, 16'h0100, 16'h0028, 16'h0030};
        {init_level, match_wr, match_wdata, div_compare_val} = {8'h5a, 8'h00, 128'h0, 8'h20};
        {compare0_action, compare1_action, ovf_prio, cmp_prio, cmp_irq_en} = {4'h0, 3'h2, 3'h5, 10'h3ff};
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        @(posedge clk_sys);
        init_level <= 8'h00;
        wr(0, 16'h0010);
        wr(1, 16'h0008);
        wr(2, 16'h0004);
        wr(3, 16'h0020);
        wr(4, 16'h0018);
        @(posedge clk_sys);
        run <= 1'b1;
        t_wave();
        t_reload();
        t_group();
        t_ovf();
        t_div();
        final_report();
    end
endmodule
